// ==== core/dor_pkg.sv ====
// Constants and register map of the digital output router.
package dor_pkg;
	localparam int CLK_MHZ = 100;
	localparam int CLK_HZ = CLK_MHZ * 1000000;
	localparam int NUM_OUT = 4;
	localparam int NUM_ROUTE = NUM_OUT + 1;
	localparam int GPO_LSB = 16;
	localparam int SOFT_PULSE_TIME_US = 250;
	localparam int OUT_PULSE_TIME_US = 1000;
	localparam int SOFT_HOLD_CYCLES = SOFT_PULSE_TIME_US * CLK_MHZ;
	localparam int OUT_HOLD_CYCLES = OUT_PULSE_TIME_US * CLK_MHZ;
	localparam logic [5:0] OFF_VALUE = 6'h00;
	localparam logic [5:0] OFF_POLARITY = 6'h04;
	localparam logic [5:0] OFF_MAN_EN = 6'h08;
	localparam logic [5:0] OFF_MAN_VAL = 6'h0c;
	localparam logic [5:0] OFF_APPLIED = 6'h10;
	localparam logic [5:0] OFF_ROUTE_EN = 6'h14;
	localparam logic [5:0] OFF_LED = 6'h18;
	localparam logic [5:0] OFF_BRAKE_CTL = 6'h1c;
	localparam logic [5:0] OFF_PWM_FREQ = 6'h20;
	localparam logic [5:0] OFF_PWM_DUTY = 6'h24;
	localparam logic [5:0] OFF_ROUTE0 = 6'h28;
	localparam logic [5:0] OFF_IO_DIR = 6'h3c;
	localparam int BRAKE_BIT = 0;
	localparam int AUTO_BRAKE_BIT = 0;
	localparam int LED_GREEN_BIT = 0;
	localparam int LED_RED_BIT = 1;
	localparam int ROUTE_INV_BIT = 7;
	localparam logic [15:0] ROUTE_OFF = 16'h0fff;
	localparam logic [15:0] ROUTE_RESET = ROUTE_OFF;
	localparam logic [11:0] PWM_FREQ_MAX = 12'h7d0;
	localparam logic [11:0] PWM_FREQ_RESET = 12'h3e8;
	localparam logic [6:0] PWM_DUTY_MIN = 7'h02;
	localparam logic [6:0] PWM_DUTY_MAX = 7'h64;
	localparam logic [6:0] PWM_DUTY_RESET = 7'h64;
	localparam logic [7:0] SRC_ONE = 8'h00;
	localparam logic [7:0] SRC_ZERO = 8'h01;
	localparam logic [7:0] SRC_ENC_DIV1 = 8'h02;
	localparam logic [7:0] SRC_ENC_DIV64 = 8'h08;
	localparam logic [7:0] SRC_POS_DIV1 = 8'h09;
	localparam logic [7:0] SRC_POS_DIV64 = 8'h0f;
	localparam logic [7:0] SRC_PWM = 8'h10;
	localparam logic [7:0] SRC_PWM_INV = 8'h11;
endpackage

// ==== core/dor_pulse_div.sv ====
// Step pulse divider with a fixed-width output pulse.
`timescale 1ns/1ns
module dor_pulse_div #(
	parameter int HOLD = 100000
) (
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic step_in,
	input wire logic [2:0] div_sel_in,
	output logic pulse_out
);
	typedef enum {DOR_IDLE, DOR_HIGH, DOR_LOW} dor_pulse_e;
	dor_pulse_e state;
	logic [5:0] cnt;
	logic [31:0] hold;
	wire [5:0] mask = 6'((7'h01 << div_sel_in) - 7'h01);
	wire fire = step_in && ((cnt & mask) == mask);
	wire hold_done = (hold == 32'(HOLD - 1));

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			cnt <= 6'h00;
		end else if (step_in) begin
			cnt <= cnt + 6'h01;
		end
	end

	// A pulse falling due while one is still being shaped is dropped, which caps the rate; every step is still counted.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			state <= DOR_IDLE;
			hold <= 32'h0;
		end else begin
			hold <= (state == DOR_IDLE || hold_done) ? 32'h0 : hold + 32'h1;
			unique case (state)
				DOR_IDLE: if (fire) state <= DOR_HIGH;
				DOR_HIGH: if (hold_done) state <= DOR_LOW;
				DOR_LOW: if (hold_done) state <= DOR_IDLE;
			endcase
		end
	end

	assign pulse_out = (state == DOR_HIGH);
endmodule

// ==== core/dor_brake_pwm.sv ====
// Brake PWM generator with frequency in hertz and duty in percent.
`timescale 1ns/1ns
module dor_brake_pwm
	import dor_pkg::*;
(
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic [11:0] freq_in,
	input wire logic [6:0] duty_in,
	output logic pwm_out
);
	logic [27:0] acc;
	// A phase accumulator avoids a hardware divider for the period.
	wire [27:0] sum = acc + 28'(freq_in);
	wire wrap = (sum >= 28'(CLK_HZ));
	wire [39:0] phase = 40'(acc) * 40'h64;
	wire [39:0] limit = 40'(duty_in) * 40'(CLK_HZ);

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			acc <= 28'h0;
			pwm_out <= 1'b0;
		end else begin
			acc <= wrap ? sum - 28'(CLK_HZ) : sum;
			pwm_out <= (phase < limit);
		end
	end
endmodule

// ==== core/dor_output_router.sv ====
// Digital output stage: value word, polarity, manual force, routing and brake.
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ns
module dor_output_router
	import dor_pkg::*;
#(
	parameter int SOFT_HOLD_CYC = SOFT_HOLD_CYCLES,
	parameter int OUT_HOLD_CYC = OUT_HOLD_CYCLES
) (
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [5:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic op_enabled_in,
	input wire logic enc_step_in,
	input wire logic pos_step_in,
	input wire logic green_blink_in,
	input wire logic red_blink_in,
	output logic [NUM_OUT-1:0] gpo_out,
	output logic [NUM_OUT-1:0] gpo_oe_out,
	output logic soft_pwm_out,
	output logic brake_out,
	output logic led_green_out,
	output logic led_red_out
);
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = wdat[b*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic src_signal(input logic [7:0] src, input logic pulse,
		input logic pwm);
		logic s;
		s = 1'b0;
		if (src == SRC_ONE) begin
			s = 1'b1;
		end else if (src == SRC_ZERO) begin
			s = 1'b0;
		end else if (src >= SRC_ENC_DIV1 && src <= SRC_POS_DIV64) begin
			s = pulse;
		end else if (src == SRC_PWM) begin
			s = pwm;
		end else if (src == SRC_PWM_INV) begin
			s = !pwm;
		end
		return s;
	endfunction

	logic [31:0] value_word;
	logic [31:0] polarity;
	logic [31:0] man_en;
	logic [31:0] man_val;
	logic [31:0] applied;
	logic route_en;
	logic [1:0] led_ctl;
	logic auto_brake;
	logic [11:0] pwm_freq;
	logic [6:0] pwm_duty;
	logic [15:0] route [NUM_ROUTE];
	logic [NUM_OUT-1:0] io_dir;
	logic brake_pwm;

	// Bus decode.
	wire req = wb_cyc_in && wb_stb_in;
	wire wr_fire = req && wb_we_in && wb_ack_out;
	wire [3:0] widx = wb_adr_in[5:2];
	wire [31:0] wmerge_val = merge(value_word, wb_dat_in, wb_sel_in);
	wire [31:0] wmerge_pol = merge(polarity, wb_dat_in, wb_sel_in);
	wire [31:0] wmerge_men = merge(man_en, wb_dat_in, wb_sel_in);
	wire [31:0] wmerge_mvl = merge(man_val, wb_dat_in, wb_sel_in);
	wire [31:0] wmerge_frq = merge(32'(pwm_freq), wb_dat_in, wb_sel_in);
	wire [31:0] wmerge_dty = merge(32'(pwm_duty), wb_dat_in, wb_sel_in);
	wire wr_value = wr_fire && widx == OFF_VALUE[5:2];
	wire wr_pol = wr_fire && widx == OFF_POLARITY[5:2];
	wire wr_men = wr_fire && widx == OFF_MAN_EN[5:2];
	wire wr_mvl = wr_fire && widx == OFF_MAN_VAL[5:2];
	wire wr_ren = wr_fire && widx == OFF_ROUTE_EN[5:2] && wb_sel_in[0];
	wire wr_led = wr_fire && widx == OFF_LED[5:2] && wb_sel_in[0];
	wire wr_brk = wr_fire && widx == OFF_BRAKE_CTL[5:2] && wb_sel_in[0];
	wire wr_dir = wr_fire && widx == OFF_IO_DIR[5:2] && wb_sel_in[0];
	wire frq_ok = wmerge_frq <= 32'(PWM_FREQ_MAX);
	wire wr_frq = wr_fire && widx == OFF_PWM_FREQ[5:2] && frq_ok;
	// duty only within its percent range
	wire dty_ok = wmerge_dty >= 32'(PWM_DUTY_MIN) && wmerge_dty <= 32'(PWM_DUTY_MAX);
	wire wr_dty = wr_fire && widx == OFF_PWM_DUTY[5:2] && dty_ok;

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			value_word <= 32'h0;
			polarity <= 32'h0;
			man_en <= 32'h0;
			man_val <= 32'h0;
		end else begin
			if (wr_value) value_word <= wmerge_val;
			if (wr_pol) polarity <= wmerge_pol;
			if (wr_men) man_en <= wmerge_men;
			if (wr_mvl) man_val <= wmerge_mvl;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			route_en <= 1'b0;
			led_ctl <= 2'h0;
			auto_brake <= 1'b0;
			io_dir <= '0;
			pwm_freq <= PWM_FREQ_RESET;
			pwm_duty <= PWM_DUTY_RESET;
		end else begin
			if (wr_ren) route_en <= wb_dat_in[0];
			if (wr_led) led_ctl <= wb_dat_in[1:0];
			if (wr_brk) auto_brake <= wb_dat_in[AUTO_BRAKE_BIT];
			// only the first pins can be outputs
			if (wr_dir) io_dir <= wb_dat_in[NUM_OUT-1:0];
			if (wr_frq) pwm_freq <= wmerge_frq[11:0];
			if (wr_dty) pwm_duty <= wmerge_dty[6:0];
		end
	end

	// Read view, one word per index; all 16 indices are mapped.
	logic [31:0] view [16];
	assign view[0] = value_word;
	assign view[1] = polarity;
	assign view[2] = man_en;
	assign view[3] = man_val;
	assign view[4] = applied;
	assign view[5] = 32'(route_en);
	assign view[6] = 32'(led_ctl);
	assign view[7] = 32'(auto_brake);
	assign view[8] = 32'(pwm_freq);
	assign view[9] = 32'(pwm_duty);
	assign view[15] = 32'(io_dir);

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0;
		end else begin
			wb_ack_out <= req && !wb_ack_out;
			if (req && !wb_ack_out) wb_dat_out <= view[widx];
		end
	end

	// automatic brake releases only while operation is enabled
	wire brake_req = auto_brake ? op_enabled_in : value_word[BRAKE_BIT];
	wire [31:0] eff_word = {value_word[31:1], brake_req};

	logic [NUM_OUT:0] route_act;
	logic [NUM_OUT:0] routed;
	logic [31:0] norm;
	assign norm[GPO_LSB-1:0] = eff_word[GPO_LSB-1:0];
	assign norm[31:GPO_LSB+NUM_OUT] = eff_word[31:GPO_LSB+NUM_OUT];

	for (genvar i = 0; i < NUM_ROUTE; i++) begin : g_route
		wire [7:0] src = route[i][15:8];
		wire [4:0] bidx = route[i][4:0];
		wire gate = eff_word[bidx] ^ route[i][ROUTE_INV_BIT];
		wire is_pos = src >= SRC_POS_DIV1 && src <= SRC_POS_DIV64;
		wire [7:0] dsel = is_pos ? src - SRC_POS_DIV1 : src - SRC_ENC_DIV1;
		wire pulse;
		wire wr_ent = wr_fire && widx == 4'(OFF_ROUTE0[5:2] + i);
		wire [31:0] ent_merge = merge(32'(route[i]), wb_dat_in, wb_sel_in);

		always_ff @(posedge mclk_in) begin
			if (srst_in) begin
				route[i] <= ROUTE_RESET;
			end else if (wr_ent) begin
				route[i] <= ent_merge[15:0];
			end
		end
		assign view[10+i] = 32'(route[i]);

		// divided step pulses; entry 0 runs at the faster rate
		dor_pulse_div #(
			.HOLD(i == 0 ? SOFT_HOLD_CYC : OUT_HOLD_CYC)
		) u_div (
			.mclk_in(mclk_in),
			.srst_in(srst_in),
			.step_in(is_pos ? pos_step_in : enc_step_in),
			.div_sel_in(dsel[2:0]),
			.pulse_out(pulse)
		);

		assign route_act[i] = route_en && route[i] != ROUTE_OFF;
		assign routed[i] = gate && src_signal(src, pulse, brake_pwm);
		if (i > 0) begin : g_gpo
			// entry i feeds output i; output n at bit 15+n
			assign norm[GPO_LSB+i-1] = route_act[i] ? routed[i] : eff_word[GPO_LSB+i-1];
		end
	end

	dor_brake_pwm u_pwm (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.freq_in(pwm_freq),
		.duty_in(pwm_duty),
		.pwm_out(brake_pwm)
	);

	// polarity; manual override; order of processing
	wire [31:0] next_applied = ((norm ^ polarity) & ~man_en) | (man_val & man_en);

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			applied <= 32'h0;
			brake_out <= 1'b0;
			soft_pwm_out <= 1'b0;
			led_green_out <= 1'b0;
			led_red_out <= 1'b0;
		end else begin
			applied <= next_applied;
			// bit 0 drives the brake; gated by PWM
			brake_out <= applied[BRAKE_BIT] && brake_pwm;
			soft_pwm_out <= route_act[0] && routed[0];
			led_green_out <= led_ctl[LED_GREEN_BIT] && green_blink_in;
			led_red_out <= led_ctl[LED_RED_BIT] && red_blink_in;
		end
	end

	assign gpo_out = applied[GPO_LSB +: NUM_OUT];
	assign gpo_oe_out = io_dir;

	wire plain16 = !route_en && !man_en[16] && !polarity[16];

	AST_DIRECT_OUT1: assert property (@(posedge mclk_in) disable iff (srst_in)
		plain16 |=> gpo_out[0] == $past(value_word[16]))
		else $error("output 1 does not follow bit 16");
	AST_POLARITY: assert property (@(posedge mclk_in) disable iff (srst_in)
		(!route_en && !man_en[17] && polarity[17]) |=> gpo_out[1] != $past(value_word[17]))
		else $error("inverted output 2 not inverted");
	AST_MANUAL: assert property (@(posedge mclk_in) disable iff (srst_in)
		man_en[BRAKE_BIT] |=> applied[BRAKE_BIT] == $past(man_val[BRAKE_BIT]))
		else $error("manual brake value not applied");
	AST_AUTO_BRAKE: assert property (@(posedge mclk_in) disable iff (srst_in)
		(auto_brake && !op_enabled_in && !man_en[0] && !polarity[0]) [*2] |=> !brake_out)
		else $error("brake released outside operation enabled");
	AST_LED_OFF: assert property (@(posedge mclk_in) disable iff (srst_in)
		!led_ctl[LED_GREEN_BIT] |=> !led_green_out)
		else $error("green LED on while disabled");
	AST_ROUTE_OFF: assert property (@(posedge mclk_in) disable iff (srst_in)
		(route_en && route[1] == ROUTE_OFF && !man_en[16] && !polarity[16])
		|=> applied[16] == $past(value_word[16]))
		else $error("disabled route did not fall back");
	AST_CONST_ONE: assert property (@(posedge mclk_in) disable iff (srst_in)
		(route_act[1] && route[1][15:8] == SRC_ONE && g_route[1].gate
		&& !man_en[16] && !polarity[16]) |=> applied[16])
		else $error("constant one source not applied");
	AST_FREQ_REJECT: assert property (@(posedge mclk_in) disable iff (srst_in)
		(wr_fire && widx == OFF_PWM_FREQ[5:2] && !frq_ok) |=> $stable(pwm_freq))
		else $error("frequency above maximum accepted");
	AST_DUTY_RANGE: assert property (@(posedge mclk_in) disable iff (srst_in)
		pwm_duty >= PWM_DUTY_MIN && pwm_duty <= PWM_DUTY_MAX)
		else $error("duty outside percent range");
	AST_ACK: assert property (@(posedge mclk_in) disable iff (srst_in)
		(req && !wb_ack_out) |=> wb_ack_out ##1 !wb_ack_out)
		else $error("bus ack not a single cycle after request");

	// The gpo_out checks below look one edge after the registers that feed the applied word; the brake check looks one edge after applied.
	AST_MAN_GPO: assert property (@(posedge mclk_in) disable iff (srst_in)
		man_en[GPO_LSB] |=> gpo_out[0] == $past(man_val[GPO_LSB]))
		else $error("manual value not applied to output 1");
	AST_ORDER: assert property (@(posedge mclk_in) disable iff (srst_in)
		(!route_en && !man_en[GPO_LSB+2])
		|=> gpo_out[2] == $past(value_word[GPO_LSB+2] ^ polarity[GPO_LSB+2]))
		else $error("output 3 not the polarity-adjusted value");
	AST_BRAKE_PIN: assert property (@(posedge mclk_in) disable iff (srst_in)
		!applied[BRAKE_BIT] |=> !brake_out)
		else $error("brake driven while applied bit 0 is clear");
	AST_RED_OFF: assert property (@(posedge mclk_in) disable iff (srst_in)
		!led_ctl[LED_RED_BIT] |=> !led_red_out)
		else $error("red LED on while disabled");
	AST_LED_ON: assert property (@(posedge mclk_in) disable iff (srst_in)
		(led_ctl[LED_GREEN_BIT] && green_blink_in) |=> led_green_out)
		else $error("enabled green LED does not follow its pattern");
	AST_DIRECT: assert property (@(posedge mclk_in) disable iff (srst_in)
		(!route_en && !man_en[GPO_LSB+3] && !polarity[GPO_LSB+3])
		|=> gpo_out[3] == $past(value_word[GPO_LSB+3]))
		else $error("output 4 not under direct control");
	AST_ROUTE_EN: assert property (@(posedge mclk_in) disable iff (srst_in)
		wr_ren |=> route_en == $past(wb_dat_in[0]))
		else $error("routing enable write lost");
	AST_CONST_ZERO: assert property (@(posedge mclk_in) disable iff (srst_in)
		(route_act[1] && route[1][15:8] == SRC_ZERO
		&& !man_en[GPO_LSB] && !polarity[GPO_LSB]) |=> !applied[GPO_LSB])
		else $error("constant zero source not applied");
	AST_GATE_OFF: assert property (@(posedge mclk_in) disable iff (srst_in)
		(route_act[1] && !g_route[1].gate && !man_en[GPO_LSB] && !polarity[GPO_LSB])
		|=> !applied[GPO_LSB])
		else $error("gated-off route still drives output 1");
	AST_PWM_ROUTE: assert property (@(posedge mclk_in) disable iff (srst_in)
		(route_act[1] && route[1][15:8] == SRC_PWM && g_route[1].gate
		&& !man_en[GPO_LSB] && !polarity[GPO_LSB])
		|=> applied[GPO_LSB] == $past(brake_pwm))
		else $error("brake PWM not routed to output 1");
	AST_SOFT_OFF: assert property (@(posedge mclk_in) disable iff (srst_in)
		!route_act[0] |=> !soft_pwm_out)
		else $error("soft PWM pin active without a route");
	AST_OE_DIR: assert property (@(posedge mclk_in) disable iff (srst_in)
		wr_dir |=> gpo_oe_out == $past(wb_dat_in[NUM_OUT-1:0]))
		else $error("pin direction not taken from the write");
	AST_FREQ_ACCEPT: assert property (@(posedge mclk_in) disable iff (srst_in)
		(wr_frq && wb_sel_in == 4'hf) |=> pwm_freq == $past(wb_dat_in[11:0]))
		else $error("valid frequency not accepted");
	AST_DUTY_ACCEPT: assert property (@(posedge mclk_in) disable iff (srst_in)
		(wr_dty && wb_sel_in == 4'hf) |=> pwm_duty == $past(wb_dat_in[6:0]))
		else $error("valid duty not accepted");
	AST_DUTY_REJECT: assert property (@(posedge mclk_in) disable iff (srst_in)
		(wr_fire && widx == OFF_PWM_DUTY[5:2] && !dty_ok) |=> $stable(pwm_duty))
		else $error("duty outside its range accepted");
	AST_READ_ROUTE: assert property (@(posedge mclk_in) disable iff (srst_in)
		(req && !wb_ack_out && !wb_we_in && widx == OFF_ROUTE0[5:2])
		|=> wb_dat_out == 32'($past(route[0])))
		else $error("soft PWM entry read back wrong");
	AST_READ_APPLIED: assert property (@(posedge mclk_in) disable iff (srst_in)
		(req && !wb_ack_out && !wb_we_in && widx == OFF_APPLIED[5:2])
		|=> wb_dat_out == $past(applied))
		else $error("applied pattern read back wrong");
	AST_WR_VALUE: assert property (@(posedge mclk_in) disable iff (srst_in)
		(wr_value && wb_sel_in == 4'hf) |=> value_word == $past(wb_dat_in))
		else $error("value word write lost");
	AST_AUTO_RELEASE: assert property (@(posedge mclk_in) disable iff (srst_in)
		(auto_brake && op_enabled_in && !man_en[BRAKE_BIT] && !polarity[BRAKE_BIT]) [*2]
		|=> brake_out == $past(brake_pwm))
		else $error("brake not released in operation enabled");
endmodule

// ==== verif/dor_load_model.sv ====
// Load on output 1 that counts the pulses it sees at the pin.
`timescale 1ns/1ns
module dor_load_model (
	input wire logic mclk_in,
	input wire logic clr_in,
	input wire logic pin_in,
	output logic [7:0] rise_cnt_out
);
	logic pin_d;
	// A pulse counts at its rising edge, so a level held across a check cannot count twice.
	always_ff @(posedge mclk_in) begin
		pin_d <= pin_in;
		if (clr_in)
			rise_cnt_out <= 8'h00;
		else if (pin_in && !pin_d)
			rise_cnt_out <= rise_cnt_out + 8'h01;
	end
endmodule

// ==== verif/test_digital_output_router.sv ====
// Self-checking bench of the digital output router.
`timescale 1ns/1ns
module test_digital_output_router import dor_pkg::*;;
	logic clk, rst, cyc, stb, we, op_en, enc, pos, blink, clr, ack;
	logic soft_pwm, brake, led_g, led_r;
	logic [5:0] adr;
	logic [3:0] sel;
	logic [31:0] dat, rdat, v, p, me, mv, e;
	logic [NUM_OUT-1:0] gpo, gpo_oe;
	logic [7:0] cnt;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [15:0] ent[8] = '{16'h0005, 16'h0005, 16'h0085, 16'h0085, 16'h0105, 16'h0fff,
		16'h1005, 16'h1105};
	logic [31:0] val[8] = '{32'h20, 32'h0, 32'h0, 32'h20, 32'h20, 32'h10000, 32'h20, 32'h20};
	logic [3:0] want[8] = '{4'h1, 4'h0, 4'h1, 4'h0, 4'h0, 4'h1, 4'h1, 4'h0};
	int err_total, n_checks;

	dor_output_router #(.SOFT_HOLD_CYC(4), .OUT_HOLD_CYC(8)) dut (.mclk_in(clk), .srst_in(rst),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
		.wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack), .op_enabled_in(op_en),
		.enc_step_in(enc), .pos_step_in(pos), .green_blink_in(blink), .red_blink_in(blink),
		.gpo_out(gpo), .gpo_oe_out(gpo_oe), .soft_pwm_out(soft_pwm), .brake_out(brake),
		.led_green_out(led_g), .led_red_out(led_r));
	dor_load_model load (.mclk_in(clk), .clr_in(clr), .pin_in(gpo[0]), .rise_cnt_out(cnt));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// The request stands until ack is seen at a rising edge, then drops for a cycle.
	task automatic wb_cycle(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50)
			chk(32'h1, 32'h0, "no ack");
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wb_wr(input logic [5:0] a, input logic [31:0] d);
		wb_cycle(1'b1, a, d);
	endtask

	task automatic wb_rd(input logic [5:0] a, input logic [31:0] x, input logic [31:0] m);
		exp_q.push_back(x);
		msk_q.push_back(m);
		wb_cycle(1'b0, a, 32'h0);
	endtask

	task automatic settle;
		repeat (4) @(posedge clk);
	endtask

	task automatic step(input logic on_enc);
		@(posedge clk);
		enc <= on_enc;
		pos <= !on_enc;
		@(posedge clk);
		enc <= 1'b0;
		pos <= 1'b0;
		repeat (19) @(posedge clk);
	endtask

	// Read data is judged against the oldest note at the edge where ack is seen.
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
			chk(rdat & msk_q[0], exp_q[0] & msk_q[0], "read data");
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end

	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		$display("[FAIL] %0t watchdog expired", $time);
		finish_test();
	end

	initial begin
		{rst, cyc, stb, we, op_en, enc, pos, clr} = 8'h80;
		{adr, sel, dat, blink} = {6'h00, 4'hf, 32'h0, 1'b1};
		void'($urandom(18113));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		wb_rd(OFF_PWM_FREQ, 32'h3e8, 32'hfff);
		wb_rd(OFF_ROUTE0, 32'h0fff, 32'hffff);
		wb_wr(OFF_IO_DIR, 32'hff);
		wb_rd(OFF_IO_DIR, 32'hf, 32'hf);
		chk(32'(gpo_oe), 32'hf, "pin direction");
		for (int i = 0; i < 4; i++) begin
			{v, p, me, mv} = {$urandom, $urandom, $urandom & 32'hfffffffe, $urandom};
			op_en <= 1'($urandom);
			wb_wr(OFF_VALUE, v);
			wb_wr(OFF_POLARITY, p);
			wb_wr(OFF_MAN_EN, me);
			wb_wr(OFF_MAN_VAL, mv);
			wb_wr(OFF_APPLIED, ~v);
			e = (me & mv) | (~me & (v ^ p));
			settle();
			wb_rd(OFF_APPLIED, e, 32'h000f0001);
			chk(32'(gpo), 32'(e[19:16]), "pins");
			chk(32'(brake), 32'(e[0]), "brake");
		end
		wb_wr(OFF_POLARITY, 32'h0);
		wb_wr(OFF_MAN_EN, 32'h0);
		wb_wr(OFF_BRAKE_CTL, 32'h1);
		wb_wr(OFF_VALUE, 32'h1);
		op_en <= 1'b0;
		settle();
		chk(32'(brake), 32'h0, "brake held");
		op_en <= 1'b1;
		settle();
		chk(32'(brake), 32'h1, "brake released");
		wb_wr(OFF_MAN_VAL, 32'h0);
		wb_wr(OFF_MAN_EN, 32'h1);
		settle();
		chk(32'(brake), 32'h0, "brake manual");
		wb_wr(OFF_MAN_EN, 32'h0);
		wb_wr(OFF_PWM_FREQ, 32'h7d1);
		wb_rd(OFF_PWM_FREQ, 32'h3e8, 32'hfff);
		wb_wr(OFF_PWM_FREQ, 32'h7d0);
		wb_rd(OFF_PWM_FREQ, 32'h7d0, 32'hfff);
		wb_wr(OFF_PWM_DUTY, 32'h65);
		wb_wr(OFF_PWM_DUTY, 32'h1);
		wb_rd(OFF_PWM_DUTY, 32'h64, 32'h7f);
		for (int k = 0; k < 4; k++) begin
			wb_wr(OFF_LED, 32'(k));
			settle();
			chk(32'({led_r, led_g}), 32'(k), "leds");
		end
		wb_wr(OFF_ROUTE_EN, 32'h1);
		wb_wr(OFF_ROUTE0, 32'h0005);
		wb_wr(OFF_VALUE, val[7]);
		settle();
		chk(32'(soft_pwm), 32'(val[7][5]), "soft pwm");
		for (int k = 0; k < 8; k++) begin
			wb_wr(OFF_ROUTE0 + 6'h04, 32'(ent[k]));
			wb_wr(OFF_VALUE, val[k]);
			settle();
			chk(32'(gpo[0]), 32'(want[k]), "routed output");
		end
		for (int c = 2; c < 16; c++) begin
			wb_wr(OFF_ROUTE0 + 6'h04, {16'h0, 8'(c), 8'h05});
			repeat (20) @(posedge clk);
			clr <= 1'b1;
			@(posedge clk);
			clr <= 1'b0;
			repeat (2 << ((c - 2) % 7)) step(c < 9);
			chk(32'(cnt), 32'h2, "divided pulses");
		end
		wb_wr(OFF_VALUE, val[5]);
		wb_wr(OFF_ROUTE_EN, 32'h0);
		settle();
		chk(32'(gpo[0]), 32'(val[5][16]), "direct again");
		finish_test();
	end
endmodule
